// [src/snf_map.vh]
`ifndef SNF_MAP_VH
`define SNF_MAP_VH
// Behaviour
// - Every opcode is eight bits, shifted in on lane zero.
// - Address and data use one, two or four lanes by instruction type.
// - Single-lane input bits are sampled on the rising clock edge.
// - Read data and status bits leave on the falling clock edge.
// - Only SPI modes 0 and 3; clock idles low or high around select.
// - Dual instructions turn serial in and out into lanes zero and one.
// - Quad instructions use all four lanes.
// - Software reset needs reset-enable 66h directly followed by reset 99h.
// - After reset pair, about 30 us of reset with all instructions ignored.
// - While supply is below threshold, nothing is recognized.
// - After power-up, write-type instructions are refused for a fixed delay.
// - Write enable latch is zero at power-up.
// - Program, erase and status write need the write enable latch set.
// - Completion of program, erase or status write clears the latch.
// - One lock bit per 126 inner blocks and 32 edge sectors.
// - A set lock bit blocks program and erase of its region.
// - Every lock bit is one at power-on.
// - Unlock instruction 39h clears the addressed lock bit.
// - Scheme select 0 uses range bits, 1 uses lock bits.
// - Complement, size, top/bottom and range bits protect none, part or all.
// - Status writes are gated by the status lock bit and the latch.
// - Three status registers, each read by its own instruction.
// - While busy, only read status and suspend are obeyed.
// - Lanes two and three carry data only with quad lane enable set.
`define SNF_CLK_MHZ 100
`define SNF_RST_US 30
`define SNF_RST_CYC (`SNF_RST_US * `SNF_CLK_MHZ)
`define SNF_PUW_US 10
`define SNF_OP_CYC 16'h0040
`define SNF_DRV_RST 2'h3
`define SNF_A_CFG 8'h00
`define SNF_A_FILL 8'h04
`define SNF_A_STAT 8'h08
`define SNF_A_SREG 8'h0c
`define SNF_A_LAST 8'h10
`define SNF_A_REF 8'h14
`define SNF_A_LKS 8'h18
`define SNF_WREN 8'h06
`define SNF_WRDI 8'h04
`define SNF_RSR1 8'h05
`define SNF_RSR2 8'h35
`define SNF_RSR3 8'h15
`define SNF_WSR1 8'h01
`define SNF_WSR2 8'h31
`define SNF_WSR3 8'h11
`define SNF_RD 8'h03
`define SNF_FRD 8'h0b
`define SNF_DOUT 8'h3b
`define SNF_QOUT 8'h6b
`define SNF_DIO 8'hbb
`define SNF_QIO 8'heb
`define SNF_PP 8'h02
`define SNF_QPP 8'h32
`define SNF_SE 8'h20
`define SNF_BE32 8'h52
`define SNF_BE64 8'hd8
`define SNF_CE 8'hc7
`define SNF_CE2 8'h60
`define SNF_LOCK 8'h36
`define SNF_UNLK 8'h39
`define SNF_RLK 8'h3d
`define SNF_SUSP 8'h75
`define SNF_RESM 8'h7a
`define SNF_RSTEN 8'h66
`define SNF_RST 8'h99
`endif

// [src/snf_front.v]
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "snf_map.vh"
module snf_front #(
   parameter PUW_CYC = `SNF_PUW_US * `SNF_CLK_MHZ,
   parameter NLOCK = 158
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire supply_ok,
   input wire cs_n,
   input wire sclk,
   input wire [3:0] lane_in,
   output reg [3:0] lane_out,
   output reg [3:0] lane_oe
);
   // Bit 0 is lane_zero (serial_in), bit 1 lane_one, 2 lane_two, 3 lane_three

   localparam [4:0] S_OPC = 5'h01;
   localparam [4:0] S_ADR = 5'h02;
   localparam [4:0] S_DUM = 5'h04;
   localparam [4:0] S_DAT = 5'h08;
   localparam [4:0] S_IGN = 5'h10;
   localparam [19:0] PUW_W = PUW_CYC;
   localparam [11:0] RST_W = `SNF_RST_CYC;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Lanes, dummy clocks and direction per opcode
   // {dummy[3:0], read, data lanes[2:0], address lanes[2:0], has address}
   function [11:0] dec;
      input [7:0] op;
      begin
         case (op)
            `SNF_RD: dec = {4'h0, 1'b1, 3'h1, 3'h1, 1'b1};
            `SNF_FRD: dec = {4'h8, 1'b1, 3'h1, 3'h1, 1'b1};
            `SNF_DOUT: dec = {4'h8, 1'b1, 3'h2, 3'h1, 1'b1};
            `SNF_QOUT: dec = {4'h8, 1'b1, 3'h4, 3'h1, 1'b1};
            `SNF_DIO: dec = {4'h4, 1'b1, 3'h2, 3'h2, 1'b1};
            `SNF_QIO: dec = {4'h6, 1'b1, 3'h4, 3'h4, 1'b1};
            `SNF_RLK: dec = {4'h0, 1'b1, 3'h1, 3'h1, 1'b1};
            `SNF_RSR1, `SNF_RSR2, `SNF_RSR3: dec = {4'h0, 1'b1, 3'h1, 3'h1, 1'b0};
            `SNF_QPP: dec = {4'h0, 1'b0, 3'h4, 3'h1, 1'b1};
            `SNF_PP, `SNF_SE, `SNF_BE32, `SNF_BE64, `SNF_LOCK, `SNF_UNLK:
               dec = {4'h0, 1'b0, 3'h1, 3'h1, 1'b1};
            default: dec = {4'h0, 1'b0, 3'h1, 3'h1, 1'b0};
         endcase
      end
   endfunction

   // Shift in one, two or four lane bits
   function [31:0] shin;
      input [31:0] x;
      input [2:0] w;
      input [3:0] l;
      begin
         case (w)
            3'h2: shin = {x[29:0], l[1:0]};
            3'h4: shin = {x[27:0], l};
            default: shin = {x[30:0], l[0]};
         endcase
      end
   endfunction

   // Top bits of a byte onto the output lanes
   function [3:0] pick;
      input [7:0] x;
      input [2:0] w;
      begin
         case (w)
            3'h2: pick = {2'h0, x[7:6]};
            3'h4: pick = x[7:4];
            default: pick = {2'h0, x[7], 1'b0};
         endcase
      end
   endfunction

   // Range protection from status bits
   function prot;
      input [23:0] a;
      input c;
      input s;
      input t;
      input [2:0] b;
      reg [24:0] sz;
      begin
         if (b == 3'h0)
            sz = 25'h0;
         else if (b == 3'h7)
            sz = 25'h1000000;
         else if (s)
            sz = 25'h1000 << ((b > 3'h4) ? 3'h3 : b - 3'h1);
         else
            sz = 25'h40000 << (b - 3'h1);
         prot = c ^ (t ? ({1'b0, a} < sz) : ({1'b0, ~a} < sz));
      end
   endfunction

   // Lock bit index: edge sectors 0..31, inner blocks 32..157
   function [7:0] lidx;
      input [23:0] a;
      begin
         if (a[22:16] == 7'h00)
            lidx = {4'h0, a[15:12]};
         else if (a[22:16] == 7'h7f)
            lidx = {4'h1, a[15:12]};
         else
            lidx = {1'b0, a[22:16]} + 8'h1f;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   reg cs_m, cs_y, cs_p, sc_m, sc_y, sc_p, sp_m, sp_y;
   reg [3:0] ln_m, ln_y;
   reg [4:0] st_q, cnt_q;
   reg [7:0] op_q, ib_q, ob_q, d0_q, d1_q;
   reg [11:0] inf_q;
   reg [31:0] ad_q;
   reg [1:0] nb_q;
   reg [3:0] ol_q;
   reg wel_q, sus_q, arm_q, bad;
   reg [15:0] bsy_q, ref_q, cfg_q;
   reg [11:0] rst_q;
   reg [19:0] pu_q;
   reg [5:0] s1_q, s2_q;
   reg [2:0] s3_q;
   reg [NLOCK-1:0] lock_q;
   reg [31:0] last_q, rdv;
   reg [7:0] fill_q, lks_q, nxt;

   wire sc_r = sc_y & ~sc_p;
   wire sc_f = ~sc_y & sc_p;
   wire cs_r = cs_y & ~cs_p;
   wire cs_f = ~cs_y & cs_p;
   wire [2:0] aw = inf_q[3:1];
   wire [2:0] dw = inf_q[6:4];
   wire rd = inf_q[7];
   wire [3:0] dum = inf_q[11:8];
   wire [7:0] op_n = {op_q[6:0], ln_y[0]};
   wire [11:0] inf_n = dec(op_n);
   wire [31:0] ad_n = shin(ad_q, aw, ln_y);
   wire [31:0] ib_n = shin({24'h0, ib_q}, dw, ln_y);
   // Busy reads low while suspended, so resume and other commands get through
   wire busy = (|bsy_q) & ~sus_q;
   wire qe = s2_q[1];
   wire status_lock_bit = s2_q[0];
   wire protect_scheme_select = s3_q[0];
   wire [7:0] sr1 = {s1_q, wel_q, busy};
   wire [7:0] sr2 = {sus_q, s2_q[5:2], 1'b0, s2_q[1:0]};
   wire [7:0] sr3 = {1'b0, s3_q[2:1], 2'h0, s3_q[0], 2'h0};
   wire [7:0] li = lidx(ad_q[23:0]);
   wire hit = protect_scheme_select ? lock_q[li] :
      prot(ad_q[23:0], s2_q[5], s1_q[4], s1_q[3], s1_q[2:0]);
   wire anyp = protect_scheme_select ? |lock_q : (s2_q[5] | (|s1_q[2:0]));
   wire rsop = op_n == `SNF_RSR1 || op_n == `SNF_RSR2 || op_n == `SNF_RSR3;
   wire quad = inf_n[6] | inf_n[3];
   wire ign = ~sp_y | (|rst_q) | (busy & ~rsop & op_n != `SNF_SUSP) |
      (quad & ~qe);
   wire ok = st_q[2] | st_q[3];
   wire done = cs_r & ok;
   wire rst_go = done & op_q == `SNF_RST & arm_q;
   wire pe_ok = pu_q == 20'h0 && wel_q;
   wire [15:0] opc = (cfg_q == 16'h0) ? 16'h0001 : cfg_q;
   wire wr = psel & penable & pwrite;
   wire ref_clr = wr && paddr == `SNF_A_REF;

   ////////////////////////////////////////////////////////////////////////
   // Link front end on sampled serial clock

   // Byte shifted out on read
   always @* begin
      case (op_q)
         `SNF_RSR1: nxt = sr1;
         `SNF_RSR2: nxt = sr2;
         `SNF_RSR3: nxt = sr3;
         `SNF_RLK: nxt = {7'h0, lock_q[li]};
         default: nxt = fill_q;
      endcase
   end

   // Synchronisers, edge finding and the instruction sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_m <= 1'b1;
         cs_y <= 1'b1;
         cs_p <= 1'b1;
         sc_m <= 1'b0;
         sc_y <= 1'b0;
         sc_p <= 1'b0;
         sp_m <= 1'b0;
         sp_y <= 1'b0;
         ln_m <= 4'h0;
         ln_y <= 4'h0;
         st_q <= S_IGN;
         cnt_q <= 5'h0;
         op_q <= 8'h0;
         inf_q <= 12'h0;
         ad_q <= 32'h0;
         ib_q <= 8'h0;
         ob_q <= 8'h0;
         ol_q <= 4'h0;
         d0_q <= 8'h0;
         d1_q <= 8'h0;
         nb_q <= 2'h0;
         lane_out <= 4'h0;
         lane_oe <= 4'h0;
      end else begin
         cs_m <= cs_n;
         cs_y <= cs_m;
         cs_p <= cs_y;
         sc_m <= sclk;
         sc_y <= sc_m;
         sc_p <= sc_y;
         sp_m <= supply_ok;
         sp_y <= sp_m;
         ln_m <= lane_in;
         ln_y <= ln_m;
         if (cs_f) begin
            st_q <= S_OPC;
            cnt_q <= 5'h0;
            nb_q <= 2'h0;
            ol_q <= 4'h0;
         end else if (cs_y || !sp_y) begin
            // Deselect or supply loss drops the lanes and ends the frame
            lane_oe <= 4'h0;
            if (!sp_y)
               st_q <= S_IGN;
         end else begin
            // Edges before the first rising one are ignored in mode 3
            case (st_q)
               S_OPC: begin
                  if (sc_r) begin
                     op_q <= op_n;
                     cnt_q <= cnt_q + 5'h1;
                     if (cnt_q == 5'h7) begin
                        inf_q <= inf_n;
                        cnt_q <= 5'h0;
                        if (ign)
                           st_q <= S_IGN;
                        else if (inf_n[0])
                           st_q <= S_ADR;
                        else
                           st_q <= (|inf_n[11:8]) ? S_DUM : S_DAT;
                     end
                  end
               end
               S_ADR: begin
                  if (sc_r) begin
                     ad_q <= ad_n;
                     cnt_q <= cnt_q + {2'h0, aw};
                     if (cnt_q + {2'h0, aw} == 5'h18) begin
                        cnt_q <= 5'h0;
                        st_q <= (|dum) ? S_DUM : S_DAT;
                     end
                  end
               end
               S_DUM: begin
                  if (sc_r) begin
                     cnt_q <= cnt_q + 5'h1;
                     if (cnt_q + 5'h1 == {1'b0, dum}) begin
                        cnt_q <= 5'h0;
                        st_q <= S_DAT;
                     end
                  end
               end
               S_DAT: begin
                  if (rd) begin
                     if (sc_f) begin
                        lane_oe <= (dw == 3'h4) ? 4'hf :
                           (dw == 3'h2) ? 4'h3 : 4'h2;
                        if (ol_q == 4'h0) begin
                           lane_out <= pick(nxt, dw);
                           ob_q <= nxt << dw;
                           ol_q <= 4'h8 - {1'b0, dw};
                        end else begin
                           lane_out <= pick(ob_q, dw);
                           ob_q <= ob_q << dw;
                           ol_q <= ol_q - {1'b0, dw};
                        end
                     end
                  end else if (sc_r) begin
                     ib_q <= ib_n[7:0];
                     cnt_q <= cnt_q + {2'h0, dw};
                     if (cnt_q + {2'h0, dw} == 5'h8) begin
                        cnt_q <= 5'h0;
                        if (nb_q == 2'h0)
                           d0_q <= ib_n[7:0];
                        if (nb_q == 2'h1)
                           d1_q <= ib_n[7:0];
                        if (nb_q != 2'h3)
                           nb_q <= nb_q + 2'h1;
                     end
                  end
               end
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Device state: write enable, protection, busy, resets

   // Refusal of an instruction ended by select
   always @* begin
      case (op_q)
         `SNF_WREN: bad = pu_q != 20'h0;
         `SNF_PP, `SNF_QPP, `SNF_SE, `SNF_BE32, `SNF_BE64:
            bad = ~pe_ok | hit;
         `SNF_CE, `SNF_CE2: bad = ~pe_ok | anyp;
         `SNF_WSR1, `SNF_WSR2, `SNF_WSR3:
            bad = ~pe_ok | status_lock_bit | nb_q == 2'h0;
         `SNF_LOCK, `SNF_UNLK: bad = ~wel_q;
         default: bad = 1'b0;
      endcase
   end

   // Execution at the end of each instruction
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wel_q <= 1'b0;
         sus_q <= 1'b0;
         arm_q <= 1'b0;
         bsy_q <= 16'h0;
         rst_q <= 12'h0;
         pu_q <= PUW_W;
         ref_q <= 16'h0;
         last_q <= 32'h0;
         s1_q <= 6'h0;
         s2_q <= 6'h0;
         s3_q <= {`SNF_DRV_RST, 1'b0};
         lock_q <= {NLOCK{1'b1}};
      end else begin
         if (busy && !sus_q) begin
            bsy_q <= bsy_q - 16'h1;
            if (bsy_q == 16'h1)
               wel_q <= 1'b0;
         end
         if (pu_q != 20'h0)
            pu_q <= pu_q - 20'h1;
         if (rst_q != 12'h0)
            rst_q <= rst_q - 12'h1;
         if (ref_clr)
            ref_q <= 16'h0;
         if (done) begin
            arm_q <= op_q == `SNF_RSTEN;
            if (bad)
               ref_q <= ref_q + 16'h1;
            else begin
               case (op_q)
                  `SNF_WREN: wel_q <= 1'b1;
                  `SNF_WRDI: wel_q <= 1'b0;
                  `SNF_PP, `SNF_QPP, `SNF_SE, `SNF_BE32, `SNF_BE64,
                  `SNF_CE, `SNF_CE2: begin
                     bsy_q <= opc;
                     last_q <= {op_q, ad_q[23:0]};
                  end
                  `SNF_WSR1: begin
                     s1_q <= d0_q[7:2];
                     if (nb_q != 2'h1)
                        s2_q <= {d1_q[6], s2_q[4:2] | d1_q[5:3], d1_q[1:0]};
                     bsy_q <= opc;
                  end
                  `SNF_WSR2: begin
                     s2_q <= {d0_q[6], s2_q[4:2] | d0_q[5:3], d0_q[1:0]};
                     bsy_q <= opc;
                  end
                  `SNF_WSR3: begin
                     s3_q <= {d0_q[6:5], d0_q[2]};
                     bsy_q <= opc;
                  end
                  `SNF_LOCK: lock_q[li] <= 1'b1;
                  `SNF_UNLK: lock_q[li] <= 1'b0;
                  `SNF_SUSP: sus_q <= busy;
                  `SNF_RESM: sus_q <= 1'b0;
                  default: ;
               endcase
            end
         end
         // Software reset or supply loss clear the latch, suspend, busy and arm, and set every lock bit
         if (rst_go || !sp_y) begin
            wel_q <= 1'b0;
            sus_q <= 1'b0;
            arm_q <= 1'b0;
            bsy_q <= 16'h0;
            lock_q <= {NLOCK{1'b1}};
            rst_q <= rst_go ? RST_W : 12'h0;
         end
         if (!sp_y) begin
            pu_q <= PUW_W;
            s2_q[0] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states

   assign pready = 1'b1;

   // Read mux
   always @* begin
      case (paddr)
         `SNF_A_CFG: rdv = {16'h0, cfg_q};
         `SNF_A_FILL: rdv = {24'h0, fill_q};
         `SNF_A_STAT: rdv = {24'h0, 1'b0, sp_y, arm_q, |rst_q, |pu_q, sus_q, wel_q, busy};
         `SNF_A_SREG: rdv = {8'h0, sr3, sr2, sr1};
         `SNF_A_LAST: rdv = last_q;
         `SNF_A_REF: rdv = {16'h0, ref_q};
         `SNF_A_LKS: rdv = {23'h0, lks_q < NLOCK ? lock_q[lks_q] : 1'b0, lks_q};
         default: rdv = 32'h0;
      endcase
   end

   // Registers written in the access cycle, answer captured in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= `SNF_OP_CYC;
         fill_q <= 8'h0;
         lks_q <= 8'h0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         if (psel && !penable) begin
            prdata <= rdv;
            pslverr <= paddr > `SNF_A_LKS || paddr[1:0] != 2'h0;
         end
         if (wr && paddr == `SNF_A_CFG)
            cfg_q <= pwdata[15:0];
         if (wr && paddr == `SNF_A_FILL)
            fill_q <= pwdata[7:0];
         if (wr && paddr == `SNF_A_LKS)
            lks_q <= pwdata[7:0];
      end
   end

endmodule

// [testbench/snf_front_props.sv]
`timescale 1ns/10ps
module snf_front_chk #(
   parameter PUW_CYC = 1000,
   parameter NLOCK = 158
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire supply_ok,
   input wire cs_n,
   input wire sclk,
   input wire [3:0] lane_out,
   input wire [3:0] lane_oe
);
   reg sclk_d;
   reg [3:0] since_fall_q;
   reg [3:0] rises_q;
   wire acc = psel && penable;
   wire bad = (paddr > 8'h18) || (paddr[1:0] != 2'h0);
   // Cycles since the last link clock fall, link clock rises in this frame
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_d <= 1'b0;
         since_fall_q <= 4'hf;
         rises_q <= 4'h0;
      end else begin
         sclk_d <= sclk;
         if (sclk_d && !sclk)
            since_fall_q <= 4'h0;
         else if (since_fall_q != 4'hf)
            since_fall_q <= since_fall_q + 4'h1;
         if (cs_n)
            rises_q <= 4'h0;
         else if (!sclk_d && sclk && rises_q != 4'hf)
            rises_q <= rises_q + 4'h1;
      end
   end
   ////////////////////////////////////////
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus answers
   pready_high_a: assert property (pready)
      else $error("pready low");
   err_unmapped_a: assert property (acc && bad |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   ok_mapped_a: assert property (acc && !bad |-> !pslverr)
      else $error("mapped access refused");
   // Link lanes
   idle_lanes_off_a: assert property (cs_n [*5] |-> lane_oe == 4'h0)
      else $error("lane driven while deselected");
   supply_off_a: assert property (!supply_ok [*5] |-> lane_oe == 4'h0)
      else $error("lane driven with supply low");
   opcode_quiet_a: assert property (!cs_n && rises_q < 4'h8 |-> lane_oe == 4'h0)
      else $error("lane driven during opcode");
   lane_width_a: assert property (lane_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("illegal lane set driven");
   out_on_fall_a: assert property ($changed(lane_out) && lane_oe != 4'h0 |-> since_fall_q <= 4'h6)
      else $error("output moved away from a falling edge");
   cover property (lane_oe == 4'h2);
   cover property (lane_oe == 4'h3);
   cover property (lane_oe == 4'hf);
   cover property (acc && pslverr);
endmodule
bind snf_front snf_front_chk #(.PUW_CYC(PUW_CYC), .NLOCK(NLOCK)) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
   .cs_n(cs_n), .sclk(sclk), .lane_out(lane_out), .lane_oe(lane_oe)
);

// [testbench/snf_host.sv]
`timescale 1ns/10ps
module snf_host (
   input wire pclk,
   output reg cs_n = 1'b1,
   output reg sclk = 1'b0,
   output wire [3:0] lane_in,
   input wire [3:0] lane_out,
   input wire [3:0] lane_oe,
   output reg rx_v = 1'b0,
   output reg [7:0] rx_q = 8'h0
);
   reg [3:0] hd = 4'h0;
   reg [3:0] ho = 4'h0;
   reg tgl = 1'b0;
   // Released data lanes keep changing, hold lanes sit pulled high
   always @(posedge pclk)
      tgl <= ~tgl;
   assign lane_in = (lane_oe & lane_out) | (~lane_oe & ho & hd)
      | (~lane_oe & ~ho & {2'b11, tgl, ~tgl});
   // One link clock: data set at the fall, held across the rise
   task tick(input [3:0] d, input [3:0] oe, output [3:0] s);
      begin
         sclk <= 1'b0;
         hd <= d;
         ho <= oe;
         repeat (8) @(posedge pclk);
         sclk <= 1'b1;
         s = lane_in;
         repeat (8) @(posedge pclk);
      end
   endtask
   // One byte over w lanes, most significant bits first
   task xb(input [7:0] b, input integer w, input rd, output [7:0] r);
      integer i;
      reg [7:0] v;
      reg [3:0] s;
      reg [3:0] mk;
      begin
         v = b;
         r = 8'h0;
         mk = 4'hf >> (4 - w);
         for (i = 0; i < 8 / w; i = i + 1) begin
            tick(v[7:4] >> (4 - w), rd ? 4'h0 : mk, s);
            r = (r << w) | ((w == 1) ? {7'h0, s[1]} : {4'h0, s & mk});
            v = v << w;
         end
      end
   endtask
   // Whole instruction inside one select period
   task cmd(input m, input [7:0] op, input ha, input [23:0] a, input integer dm,
      input integer w, input [7:0] d, input integer nd, input rd);
      integer i;
      reg [7:0] r;
      reg [3:0] s;
      begin
         sclk <= m;
         @(posedge pclk);
         cs_n <= 1'b0;
         repeat (4) @(posedge pclk);
         xb(op, 1, 1'b0, r);
         if (ha) begin
            xb(a[23:16], 1, 1'b0, r);
            xb(a[15:8], 1, 1'b0, r);
            xb(a[7:0], 1, 1'b0, r);
         end
         for (i = 0; i < dm; i = i + 1)
            tick(4'h0, 4'h0, s);
         for (i = 0; i < nd; i = i + 1)
            xb(d, w, rd, r);
         sclk <= m;
         ho <= 4'h0;
         rx_q <= r;
         rx_v <= rd;
         @(posedge pclk);
         rx_v <= 1'b0;
         repeat (8) @(posedge pclk);
         cs_n <= 1'b1;
         repeat (8) @(posedge pclk);
      end
   endtask
endmodule

// [testbench/tb_serial_nor_front_end_protect.sv]
`timescale 1ns/10ps
`include "snf_map.vh"
module tb_serial_nor_front_end_protect;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg supply_ok = 1'b1;
   reg [7:0] paddr = 8'h0;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, cs_n, sclk, rx_v;
   wire [3:0] lane_in, lane_out, lane_oe;
   wire [7:0] rx_q;
   reg [32:0] apb_q[$];
   reg [7:0] spi_q[$];
   integer n_errors = 0;
   integer n_tests = 0;
   integer cyc = 0;
   reg [31:0] rnd;
   reg [23:0] adr;
   always #5 pclk = ~pclk;
   snf_front #(.PUW_CYC(400)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_ok(supply_ok), .cs_n(cs_n), .sclk(sclk), .lane_in(lane_in),
      .lane_out(lane_out), .lane_oe(lane_oe)
   );
   snf_host host_u (
      .pclk(pclk), .cs_n(cs_n), .sclk(sclk), .lane_in(lane_in), .lane_out(lane_out),
      .lane_oe(lane_oe), .rx_v(rx_v), .rx_q(rx_q)
   );
   ////////////////////////////////////////
   task end_of_test;
      begin
         $display("Checks %0d, mismatches %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input string nm, input [32:0] e, input [32:0] s);
      begin
         n_tests = n_tests + 1;
         if (e !== s) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   // Compare each answer with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite)
         chk("apb read", apb_q.pop_front(), {pslverr, prdata});
      if (rx_v)
         chk("link byte", {25'h0, spi_q.pop_front()}, {25'h0, rx_q});
   end
   // Cut a hang short
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         n_errors = n_errors + 1;
         end_of_test;
      end
   end
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task rd(input [7:0] a, input [32:0] e);
      begin
         apb_q.push_back(e);
         apb(1'b0, a, 32'h0);
      end
   endtask
   task op(input [7:0] x);
      host_u.cmd(1'b0, x, 1'b0, 24'h0, 0, 1, 8'h0, 0, 1'b0);
   endtask
   task wsr(input [7:0] x, input [7:0] d);
      host_u.cmd(1'b0, x, 1'b0, 24'h0, 0, 1, d, 1, 1'b0);
   endtask
   task aop(input [7:0] x, input integer n);
      host_u.cmd(1'b0, x, 1'b1, adr, 0, 1, rnd[23:16], n, 1'b0);
   endtask
   task rsr(input [7:0] x, input [7:0] e);
      begin
         spi_q.push_back(e);
         host_u.cmd(1'b0, x, 1'b0, 24'h0, 0, 1, 8'h0, 1, 1'b1);
      end
   endtask
   // Main sequence
   initial begin
      rnd = $urandom(5);
      rnd = $urandom;
      adr = {8'h09, rnd[15:0]};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      op(`SNF_WREN);
      rd(`SNF_A_STAT, 33'h48);
      rd(`SNF_A_REF, 33'h1);
      rd(`SNF_A_SREG, 33'h600000);
      rd(`SNF_A_CFG, 33'h40);
      rd(8'h1c, 33'h100000000);
      rd(8'h02, 33'h100000000);
      repeat (400) @(posedge pclk);
      rd(`SNF_A_STAT, 33'h40);
      apb(1'b1, `SNF_A_CFG, 32'h4);
      apb(1'b1, `SNF_A_REF, 32'h0);
      wsr(`SNF_WSR1, 8'h1c);
      rd(`SNF_A_REF, 33'h1);
      op(`SNF_WREN);
      rsr(`SNF_RSR1, 8'h02);
      wsr(`SNF_WSR1, 8'h1c);
      repeat (20) @(posedge pclk);
      rd(`SNF_A_SREG, 33'h60001c);
      op(`SNF_WREN);
      aop(`SNF_PP, 1);
      rd(`SNF_A_REF, 33'h2);
      op(`SNF_WREN);
      wsr(`SNF_WSR3, 8'h64);
      repeat (20) @(posedge pclk);
      rd(`SNF_A_SREG, 33'h64001c);
      apb(1'b1, `SNF_A_LKS, 32'h28);
      rd(`SNF_A_LKS, 33'h128);
      op(`SNF_WREN);
      aop(`SNF_UNLK, 0);
      rd(`SNF_A_LKS, 33'h28);
      aop(`SNF_PP, 1);
      repeat (20) @(posedge pclk);
      rd(`SNF_A_LAST, {9'h02, adr});
      rd(`SNF_A_STAT, 33'h40);
      rd(`SNF_A_REF, 33'h2);
      op(`SNF_RSTEN);
      rd(`SNF_A_STAT, 33'h60);
      op(`SNF_RST);
      op(`SNF_WREN);
      rd(`SNF_A_STAT, 33'h50);
      rd(`SNF_A_LKS, 33'h128);
      repeat (3000) @(posedge pclk);
      op(`SNF_WREN);
      rsr(`SNF_RSR1, 8'h1e);
      apb(1'b1, `SNF_A_FILL, {24'h0, rnd[23:16]});
      spi_q.push_back(rnd[23:16]);
      host_u.cmd(1'b1, `SNF_DOUT, 1'b1, adr, 8, 2, 8'h0, 1, 1'b1);
      apb(1'b1, `SNF_A_CFG, 32'h400);
      op(`SNF_WREN);
      wsr(`SNF_WSR2, 8'h02);
      op(`SNF_SUSP);
      rsr(`SNF_RSR2, 8'h82);
      op(`SNF_RESM);
      rd(`SNF_A_STAT, 33'h43);
      repeat (1000) @(posedge pclk);
      rd(`SNF_A_SREG, 33'h64021c);
      spi_q.push_back(rnd[23:16]);
      host_u.cmd(1'b0, `SNF_QOUT, 1'b1, adr, 8, 4, 8'h0, 1, 1'b1);
      supply_ok <= 1'b0;
      repeat (10) @(posedge pclk);
      supply_ok <= 1'b1;
      repeat (420) @(posedge pclk);
      rd(`SNF_A_STAT, 33'h40);
      end_of_test;
   end
endmodule
